//--- rtl/eeprom_port_defines.svh
// Purpose: Constants for the parallel EEPROM host controller
// Assumes: 10 MHz system clock, Wishbone classic slave port
// Notes: Times are in their own units; cycle counts derive from them
`ifndef EEPROM_PORT_DEFINES_SVH
`define EEPROM_PORT_DEFINES_SVH

// ==========================================================
// Clock and timing
`define CLK_MHZ 10
`define PROG_MAX_US 3000
`define ERASE_PULSE_US 10000
`define POWERUP_WRITE_US 10000
`define PAGE_WINDOW_US 100
`define STROBE_CYCLES 3
`define PAGE_BYTES 64

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_DATA 4'h8
`define REG_STAT 4'hC

// ==========================================================
// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_CMD_LSB 1
`define CTRL_CMD_MSB 2
`define CTRL_POLL_BIT 3

// ==========================================================
// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_READY_BIT 2
`define STAT_ARMED_BIT 3
`define STAT_ERR_BIT 4

// ==========================================================
// Pin level positions
`define ADDR_W 11
`define PAGE_LSB 6
`define POLL_POS 7
`define FLIP_POS 6
`endif

//--- rtl/eeprom_port_pkg.sv
// Purpose: Types for the parallel EEPROM host controller
// Assumes: Used with eeprom_port_defines.svh
// Notes: Commands and sequencer states
package eeprom_port_pkg;
	// ==========================================================
	// Host commands
	typedef enum logic [1:0] {
		cmd_read_type = 2'h0,
		cmd_write_type = 2'h1,
		cmd_erase_type = 2'h2,
		cmd_idle_type = 2'h3
	} cmd_type;

	// Sequencer states
	typedef enum logic [2:0] {
		st_idle, st_setup, st_strobe, st_recover, st_wait_done
	} seq_state_type;
endpackage

//--- rtl/tick_timer.sv
// Purpose: Down counter for pin timing and waits
// Assumes: Single clock, load has priority over count
// Notes: expired is a registered level
`timescale 1ns/1ps
`include "eeprom_port_defines.svh"
module tick_timer #(
	parameter int WIDTH = 24
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] value_in,
	output logic expired_out
);
	// State of the counter
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic expired;
	} timer_state_type;

	timer_state_type cur_ff, nxt_cur;

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_cur = cur_ff;
		if (load_in) begin
			nxt_cur.cnt = value_in;
			nxt_cur.expired = 1'b0;
		end else if (cur_ff.cnt != '0) begin
			nxt_cur.cnt = cur_ff.cnt - 1'b1;
		end else begin
			nxt_cur.expired = 1'b1;
		end
	end

	// Register update
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_ff <= '{cnt: '0, expired: 1'b1};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign expired_out = cur_ff.expired;
endmodule

//--- rtl/eeprom_host.sv
// Purpose: Host controller driving a 2K x 8 parallel EEPROM over its pins
// Assumes: Wishbone classic slave for software, 10 MHz clock
// Notes: Erase voltage on the output-enable line is an extra select output
//
// What this block does
// - Write: select and store low, output high
// - Keep page index fixed within page
// - Next page byte within load window
// - Erase: high voltage, ten millisecond store pulse
// - Wait powerup delay before any write
`timescale 1ns/1ps
`include "eeprom_port_defines.svh"
module eeprom_host #(
	parameter int PROG_CYCLES = `PROG_MAX_US * `CLK_MHZ,
	parameter int ERASE_CYCLES = `ERASE_PULSE_US * `CLK_MHZ,
	parameter int POWERUP_CYCLES = `POWERUP_WRITE_US * `CLK_MHZ,
	parameter int WINDOW_CYCLES = `PAGE_WINDOW_US * `CLK_MHZ
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Wishbone classic slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Memory pins
	output logic [`ADDR_W-1:0] byte_addr_out,
	output logic chip_select_n_out,
	output logic output_drive_n_out,
	output logic store_strobe_n_out,
	output logic erase_voltage_out,
	input wire logic [7:0] data_pins_in,
	output logic [7:0] data_pins_out,
	output logic data_pins_oe_n_out,
	input wire logic write_done_flag_in
);
	localparam int TW = 24;

	// Controller state apart from the synchronisers, timer and power-up counter
	typedef struct packed {
		eeprom_port_pkg::seq_state_type st;
		eeprom_port_pkg::cmd_type cmd;
		logic poll;
		logic [`ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [7:0] last_wdata;
		logic [`ADDR_W-`PAGE_LSB-1:0] page;
		logic [6:0] page_cnt;
		logic page_open;
		logic [1:0] scnt;
		logic busy;
		logic done;
		logic err;
		logic armed;
		logic pu_seen;
		logic [31:0] dat;
		logic ack;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic hv;
		logic dq_oe_n;
		logic load;
		logic [TW-1:0] tval;
	} host_state_type;

	host_state_type cur_ff, nxt_cur;
	logic timer_exp;
	logic [1:0] rdy_sync_ff;
	logic [7:0] dq_s1_ff, dq_s2_ff;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdy_sync_ff <= 2'h0;
			dq_s1_ff <= 8'h00;
			dq_s2_ff <= 8'h00;
		end else begin
			rdy_sync_ff <= {rdy_sync_ff[0], write_done_flag_in};
			dq_s1_ff <= data_pins_in;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	// Shared timer for strobes, windows and waits
	tick_timer #(.WIDTH(TW)) u_timer (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.load_in(cur_ff.load),
		.value_in(cur_ff.tval),
		.expired_out(timer_exp)
	);

	// Power-up hold-off counter
	logic [TW-1:0] pu_cnt_ff;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pu_cnt_ff <= '0;
		end else if (pu_cnt_ff != TW'(POWERUP_CYCLES)) begin
			pu_cnt_ff <= pu_cnt_ff + 1'b1;
		end
	end

	wire ready_pin = rdy_sync_ff[1];
	wire wb_req = wb_cyc_in && wb_stb_in && !cur_ff.ack;
	wire pu_ok = (pu_cnt_ff == TW'(POWERUP_CYCLES));

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.ack = 1'b0;
		nxt_cur.load = 1'b0;
		nxt_cur.pu_seen = pu_ok;
		// Software access: one-cycle ack after request
		if (wb_req) begin
			nxt_cur.ack = 1'b1;
			nxt_cur.dat = 32'h0000_0000;
			unique case (wb_adr_in)
				`REG_CTRL: begin
					if (wb_we_in && wb_sel_in[0]) begin
						nxt_cur.poll = wb_dat_in[`CTRL_POLL_BIT];
						if (wb_dat_in[`CTRL_GO_BIT] && cur_ff.st == eeprom_port_pkg::st_idle && !cur_ff.busy) begin
							nxt_cur.cmd = eeprom_port_pkg::cmd_type'(wb_dat_in[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);
							nxt_cur.busy = 1'b1;
							nxt_cur.done = 1'b0;
							nxt_cur.err = 1'b0;
						end
					end
					nxt_cur.dat[`CTRL_POLL_BIT] = cur_ff.poll;
				end
				`REG_ADDR: begin
					if (wb_we_in && !cur_ff.busy) begin
						nxt_cur.addr = wb_dat_in[`ADDR_W-1:0];
					end
					nxt_cur.dat[`ADDR_W-1:0] = cur_ff.addr;
				end
				`REG_DATA: begin
					if (wb_we_in && wb_sel_in[0] && !cur_ff.busy) begin
						nxt_cur.wdata = wb_dat_in[7:0];
					end
					nxt_cur.dat[7:0] = cur_ff.rdata;
				end
				`REG_STAT: begin
					nxt_cur.dat[`STAT_BUSY_BIT] = cur_ff.busy;
					nxt_cur.dat[`STAT_DONE_BIT] = cur_ff.done;
					nxt_cur.dat[`STAT_READY_BIT] = ready_pin;
					nxt_cur.dat[`STAT_ARMED_BIT] = cur_ff.page_open;
					nxt_cur.dat[`STAT_ERR_BIT] = cur_ff.err;
				end
				default: begin
					nxt_cur.dat = 32'h0000_0000;
				end
			endcase
		end
		// Page closes on device side once window lapses; a load still in flight leaves a stale expiry
		if (cur_ff.page_open && cur_ff.st == eeprom_port_pkg::st_idle && timer_exp && !cur_ff.load) begin
			nxt_cur.page_open = 1'b0;
			nxt_cur.page_cnt = 7'h00;
			nxt_cur.tval = TW'(PROG_CYCLES);
			nxt_cur.load = 1'b1;
			nxt_cur.st = eeprom_port_pkg::st_wait_done;
			nxt_cur.busy = 1'b1;
			nxt_cur.cmd = eeprom_port_pkg::cmd_idle_type;
		end
		// Pin sequencer
		unique case (cur_ff.st)
			eeprom_port_pkg::st_idle: begin
				if (cur_ff.busy && !(cur_ff.page_open && timer_exp && !cur_ff.load)) begin
					if (cur_ff.cmd == eeprom_port_pkg::cmd_read_type) begin
						nxt_cur.cs_n = 1'b0;
						nxt_cur.oe_n = 1'b0;
						nxt_cur.we_n = 1'b1;
						nxt_cur.dq_oe_n = 1'b1;
						nxt_cur.scnt = 2'(`STROBE_CYCLES);
						nxt_cur.st = eeprom_port_pkg::st_strobe;
					end else if (!pu_ok || cur_ff.cmd == eeprom_port_pkg::cmd_idle_type) begin
						nxt_cur.busy = 1'b0;
						nxt_cur.err = 1'b1;
						nxt_cur.done = 1'b1;
					end else if (cur_ff.cmd == eeprom_port_pkg::cmd_write_type && cur_ff.page_open &&
						(cur_ff.addr[`ADDR_W-1:`PAGE_LSB] != cur_ff.page ||
						cur_ff.page_cnt == 7'(`PAGE_BYTES))) begin
						nxt_cur.busy = 1'b0;
						nxt_cur.err = 1'b1;
						nxt_cur.done = 1'b1;
					end else begin
						nxt_cur.cs_n = 1'b0;
						nxt_cur.oe_n = 1'b1;
						nxt_cur.hv = (cur_ff.cmd == eeprom_port_pkg::cmd_erase_type);
						nxt_cur.dq_oe_n = nxt_cur.hv;
						nxt_cur.st = eeprom_port_pkg::st_setup;
					end
				end
			end
			eeprom_port_pkg::st_setup: begin
				nxt_cur.we_n = 1'b0;
				if (cur_ff.cmd == eeprom_port_pkg::cmd_erase_type) begin
					nxt_cur.tval = TW'(ERASE_CYCLES);
					nxt_cur.load = 1'b1;
				end
				nxt_cur.scnt = 2'(`STROBE_CYCLES);
				nxt_cur.st = eeprom_port_pkg::st_strobe;
			end
			eeprom_port_pkg::st_strobe: begin
				if (cur_ff.scnt != 2'h0) begin
					nxt_cur.scnt = cur_ff.scnt - 2'h1;
				end else if (cur_ff.cmd != eeprom_port_pkg::cmd_erase_type || (timer_exp && !cur_ff.load)) begin
					nxt_cur.we_n = 1'b1;
					nxt_cur.oe_n = 1'b1;
					nxt_cur.st = eeprom_port_pkg::st_recover;
					if (cur_ff.cmd == eeprom_port_pkg::cmd_read_type) begin
						nxt_cur.rdata = dq_s2_ff;
					end
				end
			end
			eeprom_port_pkg::st_recover: begin
				nxt_cur.cs_n = 1'b1;
				nxt_cur.hv = 1'b0;
				nxt_cur.dq_oe_n = 1'b1;
				if (cur_ff.cmd == eeprom_port_pkg::cmd_write_type) begin
					nxt_cur.page_open = 1'b1;
					nxt_cur.page = cur_ff.addr[`ADDR_W-1:`PAGE_LSB];
					nxt_cur.page_cnt = cur_ff.page_cnt + 7'h01;
					nxt_cur.last_wdata = cur_ff.wdata;
					nxt_cur.tval = TW'(WINDOW_CYCLES);
					nxt_cur.load = 1'b1;
					nxt_cur.busy = 1'b0;
					nxt_cur.done = 1'b1;
					nxt_cur.st = eeprom_port_pkg::st_idle;
				end else if (cur_ff.cmd == eeprom_port_pkg::cmd_erase_type) begin
					nxt_cur.tval = TW'(PROG_CYCLES);
					nxt_cur.load = 1'b1;
					nxt_cur.scnt = 2'(`STROBE_CYCLES);
					nxt_cur.st = eeprom_port_pkg::st_wait_done;
				end else begin
					nxt_cur.busy = 1'b0;
					nxt_cur.done = 1'b1;
					nxt_cur.st = eeprom_port_pkg::st_idle;
				end
			end
			eeprom_port_pkg::st_wait_done: begin
				// Let the busy flag cross the synchroniser before its level is trusted
				if (cur_ff.scnt != 2'h0) begin
					nxt_cur.scnt = cur_ff.scnt - 2'h1;
				// End on timer expiry, or on released flag when polling is not chosen
				end else if (!cur_ff.load && (timer_exp || (cur_ff.poll ? 1'b0 : ready_pin))) begin
					nxt_cur.busy = 1'b0;
					nxt_cur.done = 1'b1;
					nxt_cur.err = timer_exp && !ready_pin;
					nxt_cur.st = eeprom_port_pkg::st_idle;
				end
			end
			default: begin
				nxt_cur.st = eeprom_port_pkg::st_idle;
			end
		endcase
	end

	// Register update
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_ff <= '0;
			cur_ff.cs_n <= 1'b1;
			cur_ff.oe_n <= 1'b1;
			cur_ff.we_n <= 1'b1;
			cur_ff.dq_oe_n <= 1'b1;
			cur_ff.st <= eeprom_port_pkg::st_idle;
			cur_ff.cmd <= eeprom_port_pkg::cmd_read_type;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign wb_dat_out = cur_ff.dat;
	assign wb_ack_out = cur_ff.ack;
	assign byte_addr_out = cur_ff.addr;
	assign chip_select_n_out = cur_ff.cs_n;
	assign output_drive_n_out = cur_ff.oe_n;
	assign store_strobe_n_out = cur_ff.we_n;
	assign erase_voltage_out = cur_ff.hv;
	assign data_pins_out = cur_ff.wdata;
	assign data_pins_oe_n_out = cur_ff.dq_oe_n;

	// ==========================================================
	// Assertions
	property p_read_combo;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!cur_ff.oe_n && !cur_ff.cs_n) |-> cur_ff.we_n && cur_ff.dq_oe_n;
	endproperty
	a_read_combo: assert property (p_read_combo) else $error("Read strobes wrong");

	property p_write_combo;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!cur_ff.we_n && !cur_ff.hv) |-> !cur_ff.cs_n && cur_ff.oe_n && !cur_ff.dq_oe_n;
	endproperty
	a_write_combo: assert property (p_write_combo) else $error("Write strobes wrong");

	property p_addr_stable;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!cur_ff.cs_n |=> $stable(cur_ff.addr) || $past(cur_ff.cs_n);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("Address moved in cycle");

	property p_data_hold;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		($rose(cur_ff.we_n) && !cur_ff.hv) |-> $stable(cur_ff.wdata) && !cur_ff.dq_oe_n;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("Data not held at rise");

	property p_page_same;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		($fell(cur_ff.we_n) && cur_ff.page_open) |-> cur_ff.addr[`ADDR_W-1:`PAGE_LSB] == cur_ff.page;
	endproperty
	a_page_same: assert property (p_page_same) else $error("Page index changed");

	property p_page_count;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		cur_ff.page_cnt <= 7'(`PAGE_BYTES);
	endproperty
	a_page_count: assert property (p_page_count) else $error("Page overfilled");

	property p_powerup;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$fell(cur_ff.we_n) |-> pu_ok;
	endproperty
	a_powerup: assert property (p_powerup) else $error("Write before power-up delay");

	property p_erase_voltage;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		cur_ff.hv |-> cur_ff.oe_n && cur_ff.dq_oe_n && !cur_ff.cs_n;
	endproperty
	a_erase_voltage: assert property (p_erase_voltage) else $error("Erase pins wrong");

	c_read: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $fell(cur_ff.oe_n));
	c_write: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $rose(cur_ff.page_open));
	c_erase: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $rose(cur_ff.hv));
endmodule

//--- sim/eeprom_dev_model.sv
// Purpose: Behavioural 2K x 8 parallel memory facing the host controller
// Assumes: Strobes change just after sys_clk_in edges
// Notes: Own timers count sys_clk_in cycles; a released bus shows the inverse of its last value
`timescale 1ns/1ps
module eeprom_dev_model #(
	parameter int WIN = 30,
	parameter int PU = 50,
	parameter int ERASE_MIN = 100
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	input wire logic low_supply_in,
	input wire logic [10:0] byte_addr_in,
	input wire logic chip_select_n_in,
	input wire logic output_drive_n_in,
	input wire logic store_strobe_n_in,
	input wire logic erase_voltage_in,
	input wire logic [7:0] data_pins_in,
	output logic [7:0] data_pins_out,
	output logic data_pins_oe_n_out,
	output logic write_done_low_out
);
	// ==========================================================
	// Array, page buffer and timers
	logic [7:0] mem [0:2047];
	logic [7:0] pend [0:63];
	logic [63:0] pvld = 64'h0;
	logic [10:0] lat_addr = 11'h000;
	logic [10:0] last_addr = 11'h000;
	logic [7:0] last_q = 8'h00;
	logic [7:0] held = 8'h00;
	logic [7:0] q;
	logic [4:0] page = 5'h00;
	logic [1:0] prev = 2'h3;
	logic loading = 1'b0;
	logic flip = 1'b0;
	int busy_cnt = 0, idle_cnt = 0, up_cnt = 0, low_cnt = 0, loads = 0, progs = 0, early = 0;
	initial for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
	// Open-drain flag pulled low while programming
	assign write_done_low_out = busy_cnt > 0;
	// Drive only in read mode
	assign data_pins_oe_n_out = !(!chip_select_n_in && !output_drive_n_in && store_strobe_n_in);
	always @* begin
		q = mem[byte_addr_in];
		if (busy_cnt > 0) q[6] = flip;
		if (busy_cnt > 0 && byte_addr_in == last_addr) q[7] = ~last_q[7];
		if (!data_pins_oe_n_out) held = q;
		data_pins_out = data_pins_oe_n_out ? ~held : q;
	end
	// Each read during programming flips the toggle bit
	always @(posedge output_drive_n_in) if (busy_cnt > 0 && !chip_select_n_in) flip = ~flip;
	// Address taken at the later falling strobe
	always @(negedge chip_select_n_in or negedge store_strobe_n_in) begin
		if (!chip_select_n_in && !store_strobe_n_in && output_drive_n_in) lat_addr = byte_addr_in;
	end
	// Data taken at the first rising strobe
	always @(posedge chip_select_n_in or posedge store_strobe_n_in) begin
		if (chip_select_n_in != store_strobe_n_in && output_drive_n_in && !erase_voltage_in) begin
			if (up_cnt < PU) begin
				early++;
			end else if (busy_cnt == 0 && !low_supply_in) begin
				pend[lat_addr[5:0]] = data_pins_in;
				pvld[lat_addr[5:0]] = 1'b1;
				page = lat_addr[10:6];
				loading = 1'b1;
				last_addr = lat_addr;
				last_q = data_pins_in;
				loads++;
			end
		end
	end
	// Load window, self-timed programming and erase pulse timing
	always @(posedge sys_clk_in) begin
		up_cnt = rst_n_in ? up_cnt + 1 : 0;
		idle_cnt = (prev != {chip_select_n_in, store_strobe_n_in}) ? 0 : idle_cnt + 1;
		prev = {chip_select_n_in, store_strobe_n_in};
		if (busy_cnt > 0) busy_cnt--;
		if (busy_cnt == 0) flip = 1'b0;
		if (loading && idle_cnt >= WIN) begin
			for (int i = 0; i < 64; i++) if (pvld[i]) mem[{page, i[5:0]}] = pend[i];
			pvld = 64'h0;
			loading = 1'b0;
			busy_cnt = slow_in ? 150 : 20;
			progs++;
		end
		if (!chip_select_n_in && erase_voltage_in && !store_strobe_n_in) begin
			low_cnt++;
		end else begin
			if (low_cnt >= ERASE_MIN && busy_cnt == 0 && !low_supply_in) begin
				for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
				busy_cnt = 20;
				progs++;
			end
			low_cnt = 0;
		end
	end
endmodule

//--- sim/eeprom_host_bench.sv
// Purpose: Self-checking bench for eeprom_host against the memory model
// Assumes: Shortened counts on both sides
// Notes: Registers reached by Wishbone classic single cycles
`timescale 1ns/1ps
`include "eeprom_port_defines.svh"
module eeprom_host_bench;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic slow = 1'b0;
	logic low_sup = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] stat, rq, rd_q;
	logic ack, cs_n, oe_n, we_n, erase_v, dq_oe_n, dev_oe_n, dev_busy;
	logic [10:0] mem_addr;
	logic [7:0] dq_out, dev_q;
	wire [7:0] dq;
	int errors = 0;
	int compares = 0;
	always #50 sys_clk_in = ~sys_clk_in;
	// Shared data bus: the enabled side drives it
	assign dq = !dq_oe_n ? dq_out : dev_q;
	eeprom_host #(.PROG_CYCLES(200), .ERASE_CYCLES(100), .POWERUP_CYCLES(50), .WINDOW_CYCLES(40)) dut (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rd_q), .wb_ack_out(ack),
		.byte_addr_out(mem_addr), .chip_select_n_out(cs_n), .output_drive_n_out(oe_n),
		.store_strobe_n_out(we_n), .erase_voltage_out(erase_v), .data_pins_in(dq), .data_pins_out(dq_out),
		.data_pins_oe_n_out(dq_oe_n), .write_done_flag_in(!dev_busy));
	eeprom_dev_model dev (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .slow_in(slow), .low_supply_in(low_sup),
		.byte_addr_in(mem_addr), .chip_select_n_in(cs_n), .output_drive_n_in(oe_n), .store_strobe_n_in(we_n),
		.erase_voltage_in(erase_v), .data_pins_in(dq), .data_pins_out(dev_q), .data_pins_oe_n_out(dev_oe_n),
		.write_done_low_out(dev_busy));
	// ==========================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One classic cycle, held until ack is seen
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Ack and data are read at the rising edge, before that edge updates them
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_in);
			if (ack === 1'b1) break;
		end
		if (ack !== 1'b1) begin
			chk(32'h0, 32'h1);
			tally_and_finish();
		end
		q = rd_q;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Poll status until the given bit is clear, or until it is set when it is the done bit
	task automatic wait_bit(input int b, output logic seen_low);
		int n;
		seen_low = 1'b0;
		for (n = 0; n < 300; n++) begin
			wb(1'b0, `REG_STAT, 32'h0, stat);
			if (stat[`STAT_READY_BIT] === 1'b0) seen_low = 1'b1;
			if (stat[b] === (b == `STAT_DONE_BIT)) return;
		end
		chk(stat, 32'h0);
		tally_and_finish();
	endtask
	// Wait for the load window to close, then for programming to end
	task automatic wait_prog(output logic seen_low);
		logic s1, s2;
		wait_bit(`STAT_ARMED_BIT, s1);
		wait_bit(`STAT_BUSY_BIT, s2);
		seen_low = s1 | s2;
	endtask
	task automatic byte_write(input logic [10:0] a, input logic [7:0] d);
		logic s;
		wb(1'b1, `REG_ADDR, {21'h0, a}, rq);
		wb(1'b1, `REG_DATA, {24'h0, d}, rq);
		wb(1'b1, `REG_CTRL, 32'h3, rq);
		wait_bit(`STAT_BUSY_BIT, s);
	endtask
	task automatic rd_byte(input logic [10:0] a, output logic [31:0] q);
		logic s;
		wb(1'b1, `REG_ADDR, {21'h0, a}, rq);
		wb(1'b1, `REG_CTRL, 32'h1, rq);
		wait_bit(`STAT_DONE_BIT, s);
		wb(1'b0, `REG_DATA, 32'h0, q);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk({cs_n, oe_n, we_n, dq_oe_n, erase_v}, 32'h1E);
		wb(1'b0, `REG_STAT, 32'h0, stat);
		chk(stat & 32'h15, 32'h4);
	endtask
	task automatic t_early();
		wb(1'b1, `REG_ADDR, 32'h10, rq);
		wb(1'b1, `REG_DATA, 32'h3C, rq);
		wb(1'b1, `REG_CTRL, 32'h3, rq);
		wb(1'b0, `REG_STAT, 32'h0, stat);
		chk(stat[`STAT_ERR_BIT], 32'h1);
		repeat (60) @(posedge sys_clk_in);
		chk(dev.early + dev.loads, 32'h0);
	endtask
	task automatic t_byte();
		logic s;
		byte_write(11'h7FF, 8'hA5);
		wait_prog(s);
		chk(dev.mem[11'h7FF], 32'hA5);
		rd_byte(11'h7FF, rq);
		chk(rq[7:0], 32'hA5);
	endtask
	task automatic t_page();
		int p, l;
		logic s;
		p = dev.progs;
		l = dev.loads;
		slow <= 1'b1;
		byte_write(11'h040, 8'h11);
		chk(stat[`STAT_ARMED_BIT], 32'h1);
		byte_write(11'h041, 8'h22);
		byte_write(11'h07F, 8'h33);
		wait_prog(s);
		chk(s, 32'h1);
		chk(dev.progs - p, 32'h1);
		chk(dev.loads - l, 32'h3);
		chk({dev.mem[11'h040], dev.mem[11'h041], dev.mem[11'h07F]}, 32'h112233);
		slow <= 1'b0;
	endtask
	task automatic t_cross();
		int l;
		logic s;
		l = dev.loads;
		byte_write(11'h040, 8'h44);
		wb(1'b1, `REG_ADDR, 32'h80, rq);
		wb(1'b1, `REG_DATA, 32'h55, rq);
		wb(1'b1, `REG_CTRL, 32'h3, rq);
		wait_bit(`STAT_DONE_BIT, s);
		chk(stat[`STAT_ERR_BIT], 32'h1);
		wait_prog(s);
		chk(dev.loads - l, 32'h1);
		chk({dev.mem[11'h040], dev.mem[11'h080]}, 32'h4400);
	endtask
	// Writes attempted at low supply leave the array alone
	task automatic t_supply();
		int l;
		logic s;
		l = dev.loads;
		low_sup <= 1'b1;
		byte_write(11'h100, 8'h77);
		wait_prog(s);
		chk(dev.loads - l, 32'h0);
		chk(dev.mem[11'h100], 32'h00);
		low_sup <= 1'b0;
	endtask
	task automatic t_erase();
		logic s;
		wb(1'b1, `REG_CTRL, 32'hD, rq);
		wait_bit(`STAT_DONE_BIT, s);
		chk(stat[`STAT_ERR_BIT], 32'h0);
		chk(dev.mem[11'h7FF], 32'hFF);
		rd_byte(11'h041, rq);
		chk(rq[7:0], 32'hFF);
		wb(1'b0, 4'h2, 32'h0, rq);
		chk(rq, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		t_reset();
		t_early();
		t_byte();
		t_page();
		t_cross();
		t_supply();
		t_erase();
		tally_and_finish();
	end
endmodule
